/* File: hw/bmf_pkg.sv */
/*
  constants, register map and types of the host-side message framer.
  assumes one 200 mhz clock domain shared by host bus and byte link.
*/
package bmf_pkg;
  // ----------------------------------------------------------------
  // host register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [5:0] A_CMD = 6'h00;
  localparam logic [5:0] A_CORR = 6'h04;
  localparam logic [5:0] A_IMM0 = 6'h08;
  localparam logic [5:0] A_IMM3 = 6'h14;
  localparam logic [5:0] A_CTRL = 6'h18;
  localparam logic [5:0] A_STAT = 6'h1c;
  localparam logic [5:0] A_RCMD = 6'h20;
  localparam logic [5:0] A_RCORR = 6'h24;
  localparam logic [5:0] A_RLEN = 6'h28;
  localparam logic [5:0] A_RERR = 6'h2c;
  localparam logic [5:0] A_RIMM = 6'h30;
  localparam int CTRL_GO = 8;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_TRL = 2;
  localparam int ST_LEN = 3;
  localparam int ST_NACK = 4;
  localparam int ST_OVF = 5;
  localparam int ST_MIS = 6;
  localparam logic [6:0] STAT_RST = 7'h00;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_PVER = 6'd2;
  localparam logic [5:0] OFS_ERR = 6'd6;
  localparam logic [5:0] OFS_CMD = 6'd8;
  localparam logic [5:0] OFS_CORR = 6'd12;
  localparam logic [5:0] OFS_CKT = 6'd22;
  localparam logic [5:0] OFS_ILEN = 6'd23;
  localparam logic [5:0] OFS_IMM = 6'd24;
  localparam logic [5:0] OFS_REM = 6'd40;
  localparam logic [5:0] OFS_TRL = 6'd60;
  localparam logic [5:0] HDR_LAST = 6'd43;
  localparam logic [5:0] FRAME_LAST = 6'd63;
  localparam logic [31:0] TAIL_LEN = 32'd20;
  localparam logic [31:0] CKS_LEN = 32'd16;
  localparam logic [31:0] TRL_LEN = 32'd4;
  localparam logic [31:0] MAX_PAY = 32'd8192;
  localparam logic [7:0] SYNC0 = 8'hc1;
  localparam logic [7:0] SYNC1 = 8'hc0;
  localparam logic [31:0] TRAILER = 32'hc5c4c3c2;
  localparam logic [15:0] PROTO_VER = 16'h1100;
  localparam logic [7:0] CK_NONE = 8'h00;
  localparam logic [4:0] IMM_MAX = 5'h10;
  localparam int FEAT_LSB = 20;
  localparam int SUB_LSB = 8;
  typedef enum logic [2:0] {RX_HUNT, RX_SYNC, RX_HDR, RX_PAY, RX_CKS, RX_TRL} bmf_rx_e;
endpackage

/* File: hw/bmf_host.sv */
/*
  host-side framer: builds request frames from registers, sends them
  byte-wise, parses answer frames and streams payload through a two-entry
  buffer. assumes byte link and host bus run on clk.
*/
`timescale 1ns/1ps
module bmf_host
  import bmf_pkg::*;
(
  input wire logic clk, // 200 mhz clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic [5:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  output logic [7:0] tx_data, // request byte to device
  output logic tx_valid, // request byte valid
  input wire logic tx_ready, // device takes request byte
  input wire logic [7:0] rx_data, // answer byte from device
  input wire logic rx_valid, // answer byte valid
  output logic rx_ready, // framer takes answer byte
  output logic [7:0] pl_data, // answer payload byte
  output logic pl_valid, // payload byte valid
  input wire logic pl_ready // consumer takes payload byte
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] cmd_reg, corr_reg, rcmd_reg, rcorr_reg, rlen_reg, rimm_reg, rem_reg;
  logic [127:0] imm_reg;
  logic [4:0] ilen_reg, rilen_reg;
  logic [15:0] rerr_reg;
  logic [6:0] stat_reg;
  logic [31:0] rdata_reg, rx_cnt_reg;
  logic [7:0] tx_data_reg, out_reg, skid_reg;
  logic tx_valid_reg, tx_busy_reg, out_v_reg, skid_v_reg, rx_ready_reg;
  logic [5:0] tx_idx_reg;
  bmf_rx_e rx_state_reg;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  wire w_en = ce & wr;
  wire hit_imm = addr >= A_IMM0 && addr <= A_IMM3;
  wire [1:0] imm_w = 2'(addr[5:2] - A_IMM0[5:2]);
  wire go = w_en && addr == A_CTRL && wdata[CTRL_GO] && !tx_busy_reg;
  wire [4:0] len_wr = wdata[4:0] > IMM_MAX ? IMM_MAX : wdata[4:0];
  wire [31:0] rd_mux =
    addr == A_CMD ? cmd_reg :
    addr == A_CORR ? corr_reg :
    hit_imm ? imm_reg[{imm_w, 5'b0} +: 32] :
    addr == A_CTRL ? {27'h0, ilen_reg} :
    addr == A_STAT ? {25'h0, stat_reg[6:1], tx_busy_reg} :
    addr == A_RCMD ? rcmd_reg :
    addr == A_RCORR ? rcorr_reg :
    addr == A_RLEN ? rlen_reg :
    addr == A_RERR ? {11'h0, rilen_reg, rerr_reg} :
    addr == A_RIMM ? rimm_reg : 32'h0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      cmd_reg <= 32'h0;
      corr_reg <= 32'h0;
      imm_reg <= 128'h0;
      ilen_reg <= 5'h0;
      rdata_reg <= 32'h0;
    end
    else if (ce)
    begin
      if (wr && addr == A_CMD)
        cmd_reg <= wdata;
      if (wr && addr == A_CORR)
        corr_reg <= wdata;
      if (wr && hit_imm)
        imm_reg[{imm_w, 5'b0} +: 32] <= wdata;
      if (wr && addr == A_CTRL && !tx_busy_reg)
        ilen_reg <= len_wr;
      rdata_reg <= rd ? rd_mux : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // request transmitter
  // ----------------------------------------------------------------
  wire tx_adv = ce & tx_valid_reg & tx_ready;
  wire [5:0] nidx = 6'(tx_idx_reg + 6'd1);
  wire [5:0] imm_off = 6'(nidx - OFS_IMM);
  wire [5:0] trl_off = 6'(nidx - OFS_TRL);
  wire [4:0] b8 = {nidx[1:0], 3'b0};
  logic [7:0] tx_byte;

  always_comb
  begin
    tx_byte = 8'h00;
    if (nidx == 6'd1)
      tx_byte = SYNC1;
    else if (nidx == OFS_PVER || nidx == OFS_PVER + 6'd1)
      tx_byte = PROTO_VER[{nidx[0], 3'b0} +: 8];
    else if (nidx >= OFS_CMD && nidx < OFS_CORR)
      tx_byte = cmd_reg[b8 +: 8];
    else if (nidx >= OFS_CORR && nidx < OFS_CORR + 6'd4)
      tx_byte = corr_reg[b8 +: 8];
    else if (nidx == OFS_CKT)
      tx_byte = CK_NONE;
    else if (nidx == OFS_ILEN)
      tx_byte = {3'b0, ilen_reg};
    else if (nidx >= OFS_IMM && nidx < OFS_REM)
      tx_byte = {1'b0, imm_off[4:0]} < {1'b0, ilen_reg} ?
                imm_reg[{imm_off[3:0], 3'b0} +: 8] : 8'h00;
    else if (nidx >= OFS_REM && nidx <= HDR_LAST)
      tx_byte = TAIL_LEN[b8 +: 8];
    else if (nidx >= OFS_TRL)
      tx_byte = TRAILER[5'(5'd24 - {trl_off[1:0], 3'b0}) +: 8];
  end

  // bytes 44..59 stay zero: integrity block with no check selected
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_valid_reg <= 1'b0;
      tx_busy_reg <= 1'b0;
      tx_idx_reg <= 6'h0;
      tx_data_reg <= 8'h0;
    end
    else if (go)
    begin
      tx_valid_reg <= 1'b1;
      tx_busy_reg <= 1'b1;
      tx_idx_reg <= 6'h0;
      tx_data_reg <= SYNC0;
    end
    else if (tx_adv)
    begin
      tx_idx_reg <= nidx;
      tx_data_reg <= tx_byte;
      if (tx_idx_reg == FRAME_LAST)
      begin
        tx_valid_reg <= 1'b0;
        tx_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // answer parser
  // ----------------------------------------------------------------
  wire rx_take = ce & rx_valid & rx_ready_reg;
  wire [7:0] b = rx_data;
  wire [5:0] pos = rx_cnt_reg[5:0];
  wire [31:0] rem_full = {b, rem_reg[31:8]};
  wire [31:0] pay_len = rem_full - TAIL_LEN;
  wire [11:0] feature_category_code = rcmd_reg[31:FEAT_LSB];
  wire [11:0] feature_subgroup_code = rcmd_reg[FEAT_LSB-1:SUB_LSB];
  wire [7:0] command_index_code = rcmd_reg[SUB_LSB-1:0];
  wire cmd_mis = feature_category_code != cmd_reg[31:FEAT_LSB] ||
                 feature_subgroup_code != cmd_reg[FEAT_LSB-1:SUB_LSB] ||
                 command_index_code != cmd_reg[SUB_LSB-1:0] ||
                 rcorr_reg != corr_reg;
  wire [1:0] trl_i = rx_cnt_reg[1:0];
  wire trl_bad = b != TRAILER[5'(5'd24 - {trl_i, 3'b0}) +: 8];
  wire hdr_end = rx_take && rx_state_reg == RX_HDR && pos == HDR_LAST;
  wire len_bad = hdr_end && rem_full < TAIL_LEN;
  wire ovf = hdr_end && !len_bad && pay_len > MAX_PAY;
  wire trl_err = rx_take && rx_state_reg == RX_TRL && trl_bad;
  wire done = rx_take && rx_state_reg == RX_TRL && !trl_bad && rx_cnt_reg == TRL_LEN - 32'd1;
  wire push = rx_take && rx_state_reg == RX_PAY;
  wire [6:0] st_set = {done & cmd_mis, ovf, done & (rerr_reg != 16'h0), len_bad, trl_err,
                       done, 1'b0};
  wire [6:0] st_clr = (w_en && addr == A_STAT) ? wdata[6:0] : 7'h0;

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      rx_state_reg <= RX_HUNT;
      rx_cnt_reg <= 32'h0;
      rcmd_reg <= 32'h0;
      rcorr_reg <= 32'h0;
      rem_reg <= 32'h0;
      rlen_reg <= 32'h0;
      rimm_reg <= 32'h0;
      rilen_reg <= 5'h0;
      rerr_reg <= 16'h0;
      stat_reg <= STAT_RST;
    end
    else if (ce)
    begin
      stat_reg <= (stat_reg & ~st_clr) | st_set; // set wins over clear
      if (rx_take)
      begin
        rx_cnt_reg <= rx_cnt_reg + 32'd1;
        case (rx_state_reg)
          RX_HUNT:
            if (b == SYNC0)
              rx_state_reg <= RX_SYNC;
          RX_SYNC:
          begin
            rx_cnt_reg <= {26'h0, OFS_PVER};
            if (b == SYNC1)
              rx_state_reg <= RX_HDR;
            else if (b != SYNC0)
              rx_state_reg <= RX_HUNT;
          end
          RX_HDR:
          begin
            if (pos == OFS_ERR || pos == OFS_ERR + 6'd1)
              rerr_reg <= {b, rerr_reg[15:8]};
            if (pos >= OFS_CMD && pos < OFS_CORR)
              rcmd_reg <= {b, rcmd_reg[31:8]};
            if (pos >= OFS_CORR && pos < OFS_CORR + 6'd4)
              rcorr_reg <= {b, rcorr_reg[31:8]};
            if (pos == OFS_ILEN)
              rilen_reg <= b > {3'b0, IMM_MAX} ? IMM_MAX : b[4:0];
            if (pos >= OFS_IMM && pos < OFS_IMM + 6'd4)
              rimm_reg <= {b, rimm_reg[31:8]};
            if (pos >= OFS_REM)
              rem_reg <= rem_full;
            if (pos == HDR_LAST)
            begin
              rx_cnt_reg <= 32'h0;
              rlen_reg <= pay_len;
              if (len_bad || ovf)
                rx_state_reg <= RX_HUNT;
              else if (pay_len == 32'h0)
                rx_state_reg <= RX_CKS;
              else
              begin
                rx_state_reg <= RX_PAY;
                rimm_reg <= 32'h0;
                rilen_reg <= 5'h0;
              end
            end
          end
          RX_PAY:
            if (rx_cnt_reg == rlen_reg - 32'd1)
            begin
              rx_cnt_reg <= 32'h0;
              rx_state_reg <= RX_CKS;
            end
          RX_CKS:
            if (rx_cnt_reg == CKS_LEN - 32'd1)
            begin
              rx_cnt_reg <= 32'h0;
              rx_state_reg <= RX_TRL;
            end
          RX_TRL:
            if (trl_bad || rx_cnt_reg == TRL_LEN - 32'd1)
              rx_state_reg <= RX_HUNT;
          default:
            rx_state_reg <= RX_HUNT;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // two-entry payload buffer
  // ----------------------------------------------------------------
  wire pop = ce & out_v_reg & pl_ready;
  wire skid_v_next = skid_v_reg ? !pop : (push && out_v_reg && !pop);

  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_v_reg <= 1'b0;
      skid_v_reg <= 1'b0;
      out_reg <= 8'h0;
      skid_reg <= 8'h0;
      rx_ready_reg <= 1'b0;
    end
    else if (ce)
    begin
      rx_ready_reg <= !skid_v_next;
      skid_v_reg <= skid_v_next;
      if (skid_v_reg && pop)
        out_reg <= skid_reg;
      else if (push && (!out_v_reg || pop))
        out_reg <= b;
      else if (push)
        skid_reg <= b;
      if (pop || push)
        out_v_reg <= skid_v_reg || push || (out_v_reg && !pop);
    end
  end

  assign rdata = rdata_reg;
  assign tx_data = tx_data_reg;
  assign tx_valid = tx_valid_reg;
  assign rx_ready = rx_ready_reg;
  assign pl_data = out_reg;
  assign pl_valid = out_v_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_CKTYPE: assert property (tx_valid && tx_idx_reg == OFS_CKT |-> tx_data == CK_NONE)
    else $error("checksum kind byte not zero");
  AST_ILEN: assert property (tx_valid && tx_idx_reg == OFS_ILEN |-> tx_data <= 8'h10)
    else $error("immediate length above sixteen");
  AST_REM: assert property (tx_valid && tx_idx_reg == OFS_REM |-> tx_data == 8'h14)
    else $error("remaining length byte wrong");
  AST_CMDB: assert property (tx_valid && tx_idx_reg == 6'd11 |-> tx_data == cmd_reg[31:24])
    else $error("command code byte wrong");
  AST_TRL: assert property (tx_adv && tx_idx_reg == 6'd59 |=> tx_data == 8'hc5 && tx_valid)
    else $error("trailer does not follow integrity block");
  AST_HOLD: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("request byte dropped under stall");
  AST_PAYLEN: assert property (hdr_end && !len_bad && !ovf && pay_len != 32'h0
                               |=> rlen_reg == $past(rem_full) - 32'd20)
    else $error("payload length not remaining minus twenty");
  AST_RESYNC: assert property (trl_err |=> rx_state_reg == RX_HUNT && stat_reg[ST_TRL])
    else $error("trailer fault not flagged");
  AST_IMMIGN: assert property (ce && rx_state_reg == RX_PAY |-> rilen_reg == 5'h0)
    else $error("immediate kept while payload present");
  AST_NOOVF: assert property (push |-> !skid_v_reg)
    else $error("payload byte pushed into full buffer");

  CV_SEND: cover property (tx_adv && tx_idx_reg == FRAME_LAST);
  CV_DONE: cover property (done);
  CV_TRLERR: cover property (trl_err);
  CV_FULL: cover property (skid_v_reg && out_v_reg && !pl_ready);
endmodule

/* File: tb/bmf_dev_model.sv */
/*
  far-side device model: takes 64-byte requests, answers with a frame.
  assumes the framer's clock; mode and slow are set between frames.
*/
`timescale 1ns/1ps
module bmf_dev_model
  import bmf_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // sync reset, active low
  input wire logic [7:0] tx_data, // request byte
  input wire logic tx_valid, // request byte valid
  output logic tx_ready, // request byte taken
  output logic [7:0] rx_data, // answer byte
  output logic rx_valid, // answer byte valid
  input wire logic rx_ready, // framer takes answer byte
  input wire logic [15:0] pay_len, // answer payload length
  input wire logic [15:0] err_code, // answer error number
  input wire logic [1:0] mode, // 1 bad trailer, 2 bad echo, 3 short length
  input wire logic slow // random stalls on both links
);
  logic [7:0] req [0:63];
  logic [7:0] rsp [$];
  int n;

  function automatic void put32(logic [31:0] v);
    for (int i = 0; i < 4; i++)
      rsp.push_back(v[8*i+:8]);
  endfunction

  task automatic answer();
    logic [31:0] rem;
    rem = (mode == 2'd3) ? 32'd19 : 32'(pay_len) + TAIL_LEN;
    put32(32'h1100c0c1);
    put32({err_code, 16'h0001});
    put32({req[11], req[10], req[9], req[8] ^ {7'h0, mode == 2'd2}});
    put32({req[15], req[14], req[13], req[12]});
    // four immediate bytes valued 24..27 plus filler, so the ignore rule is visible
    for (int i = 16; i < 40; i++)
      rsp.push_back(i == 23 ? 8'h04 : (i < 24 ? 8'h00 : 8'(i)));
    put32(rem);
    for (int i = 0; i < int'(pay_len) && mode != 2'd3; i++)
      rsp.push_back(8'(i * 3) ^ 8'ha5);
    for (int i = 0; i < 16; i++)
      rsp.push_back(8'h00);
    put32({mode == 2'd1 ? 8'h00 : 8'hc2, 8'hc3, 8'hc4, 8'hc5});
  endtask

  always @(posedge clk)
  begin
    if (!nrst)
    begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      n = 0;
      rsp.delete();
    end
    else
    begin
      if (tx_valid && tx_ready)
      begin
        req[n] = tx_data;
        n++;
        if (n == 64)
        begin
          answer();
          n = 0;
        end
      end
      tx_ready <= !slow || 1'($urandom_range(1));
      if (!rx_valid || rx_ready)
      begin
        if (rsp.size() != 0 && (!slow || 1'($urandom_range(1))))
        begin
          rx_data <= rsp.pop_front();
          rx_valid <= 1'b1;
        end
        else
        begin
          // released line shows a changing pattern, not the last byte
          rx_valid <= 1'b0;
          rx_data <= ~rx_data;
        end
      end
    end
  end
endmodule

/* File: tb/tb_top.sv */
/*
  self-checking bench of the host framer against the device model.
  assumes the framer and the model share one 200 mhz clock.
*/
`timescale 1ns/1ps
module tb_top
  import bmf_pkg::*;
;
  logic clk, nrst, ce, wr, rd, tx_valid, tx_ready, rx_valid, rx_ready;
  logic pl_valid, pl_ready, slow;
  logic [5:0] addr;
  logic [31:0] wdata, rdata, cmd_v, corr_v, v;
  logic [7:0] tx_data, rx_data, pl_data;
  logic [15:0] pay_len, err_code;
  logic [1:0] mode;
  logic [127:0] imm_v;
  logic [4:0] len_v;
  logic [5:0] m, e;
  int num_errors, n_compared, tx_n, pl_n, l, pay;
  int tl [8] = '{16, 31, 0, 4, 7, 2, 0, 0};
  int tp [8] = '{0, 1, 5, 8193, 3, 0, 0, 0};
  int te [8] = '{0, 4, 0, 0, 0, 0, 0, 0};
  int tm [8] = '{0, 0, 1, 0, 2, 3, 0, 0};

  bmf_host bmf_host_i(.clk(clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .pl_data(pl_data), .pl_valid(pl_valid), .pl_ready(pl_ready));
  bmf_dev_model bmf_dev_model_i(.clk(clk), .nrst(nrst), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_ready(rx_ready), .pay_len(pay_len), .err_code(err_code), .mode(mode), .slow(slow));

  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task wr_reg(logic [5:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rd_reg(logic [5:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask

  function automatic logic [7:0] exp_tx(int i);
    case (i)
      0: return 8'hc1;
      1: return 8'hc0;
      3: return 8'h11;
      8, 9, 10, 11: return cmd_v[8*(i-8)+:8];
      12, 13, 14, 15: return corr_v[8*(i-12)+:8];
      23: return {3'h0, len_v};
      40: return 8'h14;
      60: return 8'hc5;
      61: return 8'hc4;
      62: return 8'hc3;
      63: return 8'hc2;
      default: return (i >= 24 && i < 24 + int'(len_v)) ? imm_v[8*(i-24)+:8] : 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // link monitors and consumer
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    pl_ready <= 1'($urandom_range(1));
    if (nrst && tx_valid && tx_ready)
    begin
      chk("tx byte", 32'(tx_data), 32'(exp_tx(tx_n)));
      tx_n++;
    end
    if (nrst && pl_valid && pl_ready)
    begin
      chk("payload", 32'(pl_data), 32'(8'(pl_n * 3) ^ 8'ha5));
      pl_n++;
    end
  end

  initial
  begin
    #(5 * 95000);
    num_errors++;
    $display("watchdog expired");
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    {clk, nrst, wr, rd, pl_ready, slow, addr, wdata, mode} = '0;
    {pay_len, err_code, tx_n, pl_n, num_errors, n_compared} = '0;
    ce = 1'b1;
    void'($urandom(28834));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(A_STAT);
    chk("stat reset", v, 32'(STAT_RST));
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(A_CMD, 32'h5a5a5a5a);
    ce <= 1'b1;
    rd_reg(A_CMD);
    chk("ce freeze", v, 32'h0);
    rd_reg(6'h3c);
    chk("unmapped", v, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      l = (k < 6) ? tl[k] : $urandom_range(16);
      pay = (k < 6) ? tp[k] : $urandom_range(40);
      len_v = (l > 16) ? 5'h10 : 5'(l);
      cmd_v = $urandom;
      corr_v = $urandom;
      imm_v = {$urandom, $urandom, $urandom, $urandom};
      pay_len <= 16'(pay);
      err_code <= 16'(te[k]);
      mode <= 2'(tm[k]);
      slow <= (k == 3) ? 1'b0 : 1'($urandom_range(1));
      tx_n = 0;
      pl_n = 0;
      wr_reg(A_CMD, cmd_v);
      wr_reg(A_CORR, corr_v);
      for (int i = 0; i < 4; i++)
        wr_reg(A_IMM0 + 6'(4 * i), imm_v[32*i+:32]);
      wr_reg(A_CTRL, 32'h100 | 32'(l));
      wr_reg(A_CTRL, 32'h100);
      rd_reg(A_CTRL);
      chk("ctrl len", v, 32'(len_v));
      for (int t = 0; t < 20000; t++)
      begin
        rd_reg(A_STAT);
        if (v[0] === 1'b0 && v[6:1] != 6'h00)
          break;
      end
      repeat (200)
        if (pl_n < pay && pay <= 8192)
          @(posedge clk);
      chk("tx count", 32'(tx_n), 32'd64);
      case (tm[k])
        1: {m, e} = {6'h02, 6'h02};
        2: {m, e} = {6'h21, 6'h21};
        3: {m, e} = {6'h04, 6'h04};
        default: {m, e} = (pay > 8192) ? {6'h10, 6'h10} : {6'h3f, te[k] != 0 ? 6'h09 : 6'h01};
      endcase
      chk("status", 32'(v[6:1] & m), 32'(e));
      if (tm[k] == 0 && pay <= 8192)
      begin
        rd_reg(A_RCMD);
        chk("rcmd", v, cmd_v);
        rd_reg(A_RCORR);
        chk("rcorr", v, corr_v);
        rd_reg(A_RLEN);
        chk("rlen", v, 32'(pay));
        rd_reg(A_RERR);
        chk("rerr", v, {11'h0, pay == 0 ? 5'h04 : 5'h00, 16'(te[k])});
        rd_reg(A_RIMM);
        chk("rimm", v, pay == 0 ? 32'h1b1a1918 : 32'h0);
        chk("payload count", 32'(pl_n), 32'(pay));
      end
      wr_reg(A_STAT, 32'h7e);
      rd_reg(A_STAT);
      chk("stat clear", v, 32'h0);
      $display("frame %0d done", k);
    end
    tally_and_finish();
  end
endmodule
